// File: src/ila_map.svh
// Constants and encodings for the I/O interface lock arbiter
// Summary of operation
// - A lock request is answered with 1 when granted and 0 when refused.
// - Each granted request from the holder raises the lock count by one.
// - A release lowers the count by one and frees the lock at zero.
// - While locked only the holder may change state; others only query.
// - While locked, a request from a non-holder is refused, count and owner unchanged.
// - After reset the lock is free with a count of zero.
// - A lock held by LAN is freed when the LAN connection drops.
// - Operation status bit 10 is set while locked and clear when free.
// - The owner report names the holder with its LAN address, or none.
// - The caller report names the querying interface in the same form.
`ifndef ILA_MAP_SVH
`define ILA_MAP_SVH
`define ILA_CNT_W 8
`define ILA_CNT_ZERO 8'h00
`define ILA_CNT_ONE 8'h01
`define ILA_CNT_MAX 8'hff
`define ILA_IP_ZERO 32'h0000_0000
`define ILA_OPER_LOCK_BIT 10
`define ILA_OPER_W 16
`define ILA_OPER_ZERO 16'h0000
`endif

// File: src/ila_pkg.sv
// Types shared by the I/O interface lock arbiter
package ila_pkg;
  typedef enum logic [2:0] {
    ILA_IF_NONE = 3'h0,
    ILA_IF_USB = 3'h1,
    ILA_IF_VXI11 = 3'h2,
    ILA_IF_GPIB = 3'h3,
    ILA_IF_LAN = 3'h4
  } ila_if_t;
endpackage

// File: src/ila_lock_arbiter.sv
// Interface lock arbiter: nested ownership of the instrument configuration
`timescale 1ns/1ps
`include "ila_map.svh"
module ila_lock_arbiter
  import ila_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire ila_if_t cmd_if_i,
  input wire logic [31:0] cmd_ip_i,
  input wire logic ownership_request_query_i,
  input wire logic ownership_release_command_i,
  input wire logic holder_identity_query_i,
  input wire logic caller_identity_query_i,
  input wire logic change_cmd_i,
  input wire logic lan_drop_i,
  input wire logic [31:0] lan_drop_ip_i,
  output logic req_done_o,
  output logic req_grant_o,
  output logic id_valid_o,
  output ila_if_t id_if_o,
  output logic [31:0] id_ip_o,
  output logic change_ok_o,
  output logic change_block_o,
  output logic [`ILA_OPER_W-1:0] oper_cond_o,
  output logic locked_o,
  output logic [`ILA_CNT_W-1:0] lock_count_o
);

  // ****************************************
  // Decode
  // ****************************************
  logic [`ILA_CNT_W-1:0] cnt_r;
  logic [`ILA_CNT_W-1:0] cnt_nxt;
  ila_if_t own_r;
  ila_if_t own_nxt;
  logic [31:0] own_ip_r;
  logic [31:0] own_ip_nxt;

  // ****************************************
  // Helpers
  // ****************************************
  // LAN sessions differ by address, so holder match compares it too
  function automatic logic is_holder(ila_if_t ifc, logic [31:0] ip,
                                     ila_if_t own, logic [31:0] oip);
    is_holder = (ifc == own) && ((own != ILA_IF_LAN) || (ip == oip));
  endfunction

  // Only a LAN caller carries an address; the others report zero
  function automatic logic [31:0] lan_ip(ila_if_t ifc, logic [31:0] ip);
    lan_ip = (ifc == ILA_IF_LAN) ? ip : `ILA_IP_ZERO;
  endfunction

  function automatic logic is_locked(logic [`ILA_CNT_W-1:0] cnt);
    is_locked = (cnt != `ILA_CNT_ZERO);
  endfunction

  // ****************************************
  // Request path
  // ****************************************
  wire free_w = !is_locked(cnt_r);
  wire holder_w = is_holder(cmd_if_i, cmd_ip_i, own_r, own_ip_r);
  wire valid_if_w = (cmd_if_i != ILA_IF_NONE);
  // Saturated count refuses rather than wraps to a free lock
  wire grant_w = ownership_request_query_i && valid_if_w &&
                 (free_w || (holder_w && cnt_r != `ILA_CNT_MAX));
  wire rel_w = ownership_release_command_i && !free_w && holder_w;
  // A drop for another address leaves the holder alone
  wire drop_w = lan_drop_i && !free_w && own_r == ILA_IF_LAN &&
                lan_drop_ip_i == own_ip_r;
  wire allow_w = free_w || holder_w;
  // A drop in the same cycle wins, so the answer must say refused
  wire grant_ok_w = grant_w && !drop_w;

  // Drop outranks request, which outranks release
  always_comb
  begin
    cnt_nxt = cnt_r;
    own_nxt = own_r;
    own_ip_nxt = own_ip_r;
    if (drop_w)
    begin
      cnt_nxt = `ILA_CNT_ZERO;
      own_nxt = ILA_IF_NONE;
      own_ip_nxt = `ILA_IP_ZERO;
    end
    else if (grant_w)
    begin
      cnt_nxt = cnt_r + `ILA_CNT_ONE;
      own_nxt = cmd_if_i;
      own_ip_nxt = lan_ip(cmd_if_i, cmd_ip_i);
    end
    else if (rel_w)
    begin
      cnt_nxt = cnt_r - `ILA_CNT_ONE;
      if (cnt_r == `ILA_CNT_ONE)
      begin
        own_nxt = ILA_IF_NONE;
        own_ip_nxt = `ILA_IP_ZERO;
      end
    end
  end

  // ****************************************
  // Identity report
  // ****************************************
  // Holder query wins if both identity queries arrive together
  wire id_q_w = holder_identity_query_i || caller_identity_query_i;
  wire [31:0] caller_ip_w = lan_ip(cmd_if_i, cmd_ip_i);
  wire ila_if_t id_if_w = holder_identity_query_i ? own_nxt : cmd_if_i;
  wire [31:0] id_ip_w = holder_identity_query_i ? own_ip_nxt :
                        caller_ip_w;
  // Report holds between queries so a slow host can still read it
  wire ila_if_t id_if_nxt = id_q_w ? id_if_w : id_if_o;
  wire [31:0] id_ip_nxt = id_q_w ? id_ip_w : id_ip_o;

  // ****************************************
  // Status
  // ****************************************
  // Status follows the count after this cycle's update
  wire lock_nxt_w = is_locked(cnt_nxt);
  logic [`ILA_OPER_W-1:0] oper_w;
  always_comb
  begin
    oper_w = `ILA_OPER_ZERO;
    oper_w[`ILA_OPER_LOCK_BIT] = lock_nxt_w;
  end

  // ****************************************
  // State
  // ****************************************
  // Owner and count move together so a free lock never keeps an owner
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cnt_r <= `ILA_CNT_ZERO;
      own_r <= ILA_IF_NONE;
      own_ip_r <= `ILA_IP_ZERO;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      own_r <= own_nxt;
      own_ip_r <= own_ip_nxt;
    end
  end

  // ****************************************
  // Answer pulses
  // ****************************************
  // Grant is only meaningful while req_done_o is high
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      req_done_o <= 1'b0;
      req_grant_o <= 1'b0;
    end
    else
    begin
      req_done_o <= ownership_request_query_i;
      req_grant_o <= grant_ok_w;
    end
  end

  // ****************************************
  // Identity outputs
  // ****************************************
  // Valid pulses once; the report itself is held
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      id_valid_o <= 1'b0;
      id_if_o <= ILA_IF_NONE;
      id_ip_o <= `ILA_IP_ZERO;
    end
    else
    begin
      id_valid_o <= id_q_w;
      id_if_o <= id_if_nxt;
      id_ip_o <= id_ip_nxt;
    end
  end

  // ****************************************
  // Change gate
  // ****************************************
  // One pulse per command; the caller decides whether to retry
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      change_ok_o <= 1'b0;
      change_block_o <= 1'b0;
    end
    else
    begin
      change_ok_o <= change_cmd_i && allow_w;
      change_block_o <= change_cmd_i && !allow_w;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      oper_cond_o <= `ILA_OPER_ZERO;
      locked_o <= 1'b0;
      lock_count_o <= `ILA_CNT_ZERO;
    end
    else
    begin
      oper_cond_o <= oper_w;
      locked_o <= lock_nxt_w;
      lock_count_o <= cnt_nxt;
    end
  end

endmodule // ila_lock_arbiter

// File: testbench/ila_assertions.sv
// Port assertions for the lock arbiter
`timescale 1ns/1ps
module ila_chk (
  input wire logic mclk_i, srst_i, ownership_request_query_i,
  input wire logic req_done_o, req_grant_o, locked_o, change_block_o,
  input wire logic [15:0] oper_cond_o,
  input wire logic [7:0] lock_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  req_ans_a: assert property (ownership_request_query_i
    |=> req_done_o) else $error("answer");
  grant_inc_a: assert property (req_done_o && req_grant_o
    |-> lock_count_o == $past(lock_count_o) + 8'h01) else $error("inc");
  deny_hold_a: assert property (req_done_o && !req_grant_o
    |-> $stable(lock_count_o)) else $error("deny");
  grant_lock_a: assert property (req_done_o && req_grant_o
    |-> oper_cond_o[10]) else $error("grant");
  rise_req_a: assert property (lock_count_o > $past(lock_count_o)
    |-> $past(ownership_request_query_i)) else $error("rise");
  oper_bit_a: assert property (oper_cond_o == {5'h00, locked_o, 10'h000})
    else $error("oper");
  lock_lvl_a: assert property (locked_o == (lock_count_o != 8'h00))
    else $error("level");
  blk_lock_a: assert property (change_block_o |-> $past(locked_o))
    else $error("block");
endmodule // ila_chk
bind ila_lock_arbiter ila_chk u_chk(.*);

// File: testbench/ila_host.sv
// Host model, one command per call
`timescale 1ns/1ps
module ila_host
  import ila_pkg::*;
(
  input wire logic mclk_i,
  output ila_if_t cmd_if_o = ILA_IF_NONE,
  output logic [31:0] cmd_ip_o = 32'h0,
  output logic [5:0] stb_o = 6'h00
);
  task automatic send(ila_if_t f, logic [31:0] a, logic [5:0] s);
    @(posedge mclk_i);
    cmd_if_o <= f;
    cmd_ip_o <= a;
    stb_o <= s;
    @(posedge mclk_i);
    stb_o <= 6'h00;
    #1;
  endtask
endmodule // ila_host

// File: testbench/testbench.sv
// Bench for the lock arbiter
`timescale 1ns/1ps
module testbench
  import ila_pkg::*;
;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  ila_if_t cmd_if_i, id_if_o;
  logic [31:0] cmd_ip_i, id_ip_o;
  logic [5:0] s;
  logic req_done_o, req_grant_o, id_valid_o, change_ok_o;
  logic change_block_o, locked_o;
  logic [15:0] oper_cond_o;
  logic [7:0] lock_count_o;
  int errors = 0;
  int n_compared = 0;
  always #20 mclk_i = ~mclk_i;
  ila_host h(.mclk_i, .cmd_if_o(cmd_if_i), .cmd_ip_o(cmd_ip_i), .stb_o(s));
  ila_lock_arbiter dut(.*, .lan_drop_ip_i(cmd_ip_i),
    .ownership_request_query_i(s[0]), .ownership_release_command_i(s[1]),
    .holder_identity_query_i(s[2]), .caller_identity_query_i(s[3]),
    .change_cmd_i(s[4]), .lan_drop_i(s[5]));
  task automatic ck(logic [31:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task automatic op(ila_if_t f, logic [31:0] a, logic [5:0] c, logic [9:0] e);
    h.send(f, a, c);
    ck({req_done_o & req_grant_o, req_done_o, lock_count_o}, e);
  endtask
  task automatic t_nest;
    ck({locked_o, lock_count_o, oper_cond_o}, 25'h0000000);
    op(ILA_IF_USB, 32'h0, 6'h01, 10'h301);
    ck({locked_o, oper_cond_o}, 17'h10400);
    op(ILA_IF_USB, 32'h0, 6'h01, 10'h302);
    op(ILA_IF_LAN, 32'h5, 6'h01, 10'h102);
    op(ILA_IF_USB, 32'h0, 6'h02, 10'h001);
    op(ILA_IF_USB, 32'h0, 6'h02, 10'h000);
    op(ILA_IF_USB, 32'h0, 6'h02, 10'h000);
    $display("nest end");
  endtask
  task automatic t_lan;
    op(ILA_IF_LAN, 32'h5, 6'h01, 10'h301);
    op(ILA_IF_LAN, 32'h6, 6'h01, 10'h101);
    op(ILA_IF_USB, 32'h0, 6'h02, 10'h001);
    op(ILA_IF_LAN, 32'h5, 6'h10, 10'h001);
    ck(change_ok_o, 1'b1);
    op(ILA_IF_GPIB, 32'h0, 6'h10, 10'h001);
    ck(change_block_o, 1'b1);
    op(ILA_IF_GPIB, 32'h0, 6'h04, 10'h001);
    ck({id_valid_o, id_if_o}, {1'b1, ILA_IF_LAN});
    ck(id_ip_o, 32'h5);
    ck(oper_cond_o, 16'h0400);
    op(ILA_IF_LAN, 32'h6, 6'h20, 10'h001);
    op(ILA_IF_LAN, 32'h5, 6'h20, 10'h000);
    ck({locked_o, oper_cond_o}, 17'h00000);
    op(ILA_IF_GPIB, 32'h0, 6'h04, 10'h000);
    ck(id_if_o, ILA_IF_NONE);
    ck(id_ip_o, 32'h0);
    op(ILA_IF_GPIB, 32'h0, 6'h08, 10'h000);
    ck(id_if_o, ILA_IF_GPIB);
    op(ILA_IF_LAN, 32'h7, 6'h08, 10'h000);
    ck(id_if_o, ILA_IF_LAN);
    ck(id_ip_o, 32'h7);
    op(ILA_IF_GPIB, 32'h0, 6'h10, 10'h000);
    ck(change_ok_o, 1'b1);
    $display("lan end");
  endtask
  task automatic t_sat;
    for (int i = 1; i < 256; i++)
      op(ILA_IF_VXI11, 32'h0, 6'h01, {2'h3, i[7:0]});
    op(ILA_IF_VXI11, 32'h0, 6'h01, 10'h1ff);
    for (int i = 254; i >= 0; i--)
      op(ILA_IF_VXI11, 32'h0, 6'h02, {2'h0, i[7:0]});
    $display("sat end");
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2500) @(posedge mclk_i);
    errors++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_nest();
    t_lan();
    t_sat();
    finish_test();
  end
endmodule // testbench
